/* File: core/didd_input.sv */
// Purpose: 16-channel debounced digital input with field power diagnosis
// Assumes: inputs synchronous to sys_clk, Avalon-MM slave
// Notes:   one counter per channel, shared filter settings
//
// Functional notes
// - Rising edges filtered by 3-bit code: 1,3,5,10,15,20,25,30 ms; default 5
// - Falling edges use own code; rise bits 0-2, fall bits 4-6
// - Power loss detection enabled by bit 0 of second byte, default on
// - New parameters take effect only after full two-byte download
// - Diagnosis bit 2 set on power loss, cleared on recovery
// - One diagnosis report per scan with a loss or recovery pending, no repeats
// - Sixteen channels, each own filter state, shared times
// - Diagnosis delivered at the next scan period, not immediately
// - Diagnosis byte 0x04 while lost, 0x00 otherwise
`timescale 1ns/1ns
`include "didd_defines.svh"

module didd_input (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [15:0] rawIn,
  input  wire logic        fieldPowerOk,
  input  wire logic        scanTick,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [15:0] inputState,
  output logic      [7:0]  diagByte,
  output logic             diagValid,
  output logic             irq
);

  localparam int CNT_W = 20;

  // Staged bytes become live only on a full download
  didd_pkg::didd_param_s stage_r;
  didd_pkg::didd_param_s live_r;
  logic [1:0]            staged_r;
  logic [15:0]           state_r;
  didd_pkg::didd_pwr_e   pwr_r;
  logic                  pend_r;
  logic [7:0]            diag_r;
  logic                  diagValid_r;
  logic [`DIDD_IRQ_W-1:0] irqSt_r;
  logic [`DIDD_IRQ_W-1:0] irqMsk_r;
  logic                  ack_r;
  logic [31:0]           rdata_r;
  logic [CNT_W-1:0]      riseLim;
  logic [CNT_W-1:0]      fallLim;
  logic                  detEn;
  logic                  wrHit;
  logic                  rdHit;
  logic                  pwrChg;
  logic [15:0]           flip;

  function automatic logic [CNT_W-1:0] code_cyc(input logic [2:0] c);
    logic [31:0] v;
    v = 32'h0;
    case (c)
      3'h0: v = `DIDD_MS_CYC(`DIDD_T0_MS);
      3'h1: v = `DIDD_MS_CYC(`DIDD_T1_MS);
      3'h2: v = `DIDD_MS_CYC(`DIDD_T2_MS);
      3'h3: v = `DIDD_MS_CYC(`DIDD_T3_MS);
      3'h4: v = `DIDD_MS_CYC(`DIDD_T4_MS);
      3'h5: v = `DIDD_MS_CYC(`DIDD_T5_MS);
      3'h6: v = `DIDD_MS_CYC(`DIDD_T6_MS);
      default: v = `DIDD_MS_CYC(`DIDD_T7_MS);
    endcase
    return CNT_W'(v);
  endfunction : code_cyc

  assign riseLim = code_cyc(live_r.byte0[`DIDD_RISE_LSB +: `DIDD_CODE_W]);
  assign fallLim = code_cyc(live_r.byte0[`DIDD_FALL_LSB +: `DIDD_CODE_W]);
  assign detEn   = live_r.byte1[`DIDD_PDET_BIT];

  // One wait state: request taken when ack_r is high
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wrHit = avs_write & ack_r;
  assign rdHit = avs_read & ack_r;
  assign avs_readdata = rdata_r;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 32'h0;
    end else if (avs_read & ~ack_r) begin
      case (avs_address)
        `DIDD_OFF_INPUT:  rdata_r <= {16'h0, state_r};
        `DIDD_OFF_DIAG:   rdata_r <= {24'h0, diag_r};
        `DIDD_OFF_IRQST:  rdata_r <= {30'h0, irqSt_r};
        `DIDD_OFF_IRQMSK: rdata_r <= {30'h0, irqMsk_r};
        `DIDD_OFF_SCAN:   rdata_r <= {31'h0, pend_r};
        default:          rdata_r <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stage_r  <= '0;
      staged_r <= 2'h0;
      live_r   <= {`DIDD_FILT_RST, `DIDD_PWRCTL_RST};
    end else if (wrHit & avs_byteenable[0]) begin
      if (avs_address == `DIDD_OFF_FILT) begin
        stage_r.byte0 <= avs_writedata[7:0];
        staged_r[0]   <= 1'b1;
      end else if (avs_address == `DIDD_OFF_PWRCTL) begin
        stage_r.byte1 <= avs_writedata[7:0];
        staged_r[1]   <= 1'b1;
      end else if (avs_address == `DIDD_OFF_LOAD &&
                   avs_writedata[0] && staged_r == 2'h3) begin
        live_r   <= stage_r;
        staged_r <= 2'h0;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gCh
      // Per-channel registers keep each process the only writer
      logic [CNT_W-1:0] cnt_r;
      logic             st_r;
      assign flip[g]    = (cnt_r + 1'b1 >= (st_r ? fallLim : riseLim));
      assign state_r[g] = st_r;
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          cnt_r <= '0;
          st_r  <= 1'b0;
        end else if (rawIn[g] == st_r) begin
          cnt_r <= '0;
        end else if (flip[g]) begin
          cnt_r <= '0;
          st_r  <= rawIn[g];
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  endgenerate
  assign inputState = state_r;

  assign pwrChg = detEn &&
    ((pwr_r == didd_pkg::DIDD_PWR_OK) == ~fieldPowerOk);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pwr_r <= didd_pkg::DIDD_PWR_OK;
    end else if (!detEn) begin
      pwr_r <= didd_pkg::DIDD_PWR_OK;
    end else if (pwrChg) begin
      pwr_r <= fieldPowerOk ? didd_pkg::DIDD_PWR_OK
                            : didd_pkg::DIDD_PWR_LOST;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pend_r      <= 1'b0;
      diag_r      <= `DIDD_DIAG_NONE;
      diagValid_r <= 1'b0;
    end else begin
      diagValid_r <= 1'b0;
      if (pwrChg) begin
        pend_r <= 1'b1;
      end else if (scanTick & pend_r) begin
        pend_r      <= 1'b0;
        diagValid_r <= 1'b1;
        diag_r <= (pwr_r == didd_pkg::DIDD_PWR_LOST) ? `DIDD_DIAG_LOSS
                                                    : `DIDD_DIAG_NONE;
      end else if (!detEn) begin
        diag_r <= `DIDD_DIAG_NONE;
      end
    end
  end
  assign diagByte  = diag_r;
  assign diagValid = diagValid_r;

  // Set wins over write-one-to-clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irqSt_r  <= '0;
      irqMsk_r <= '0;
    end else begin
      for (int i = 0; i < `DIDD_IRQ_W; i++) begin
        if (wrHit && avs_address == `DIDD_OFF_IRQST &&
            avs_byteenable[0] && avs_writedata[i])
          irqSt_r[i] <= 1'b0;
      end
      if (diagValid_r) irqSt_r[`DIDD_IRQ_DIAG] <= 1'b1;
      if (|flip & (rawIn != state_r)) irqSt_r[`DIDD_IRQ_INPUT] <= 1'b1;
      if (wrHit && avs_address == `DIDD_OFF_IRQMSK && avs_byteenable[0])
        irqMsk_r <= avs_writedata[`DIDD_IRQ_W-1:0];
    end
  end
  assign irq = |(irqSt_r & irqMsk_r);

  diag_code_a: assert property (@(posedge sys_clk) disable iff (reset)
    diag_r == `DIDD_DIAG_LOSS || diag_r == `DIDD_DIAG_NONE)
    else $error("Diagnosis byte has illegal value");

  diag_scan_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(diagValid_r) |-> $past(scanTick) && $past(pend_r))
    else $error("Diagnosis sent outside a scan");

  diag_once_a: assert property (@(posedge sys_clk) disable iff (reset)
    diagValid_r |=> !diagValid_r)
    else $error("Diagnosis repeated");

  diag_loss_a: assert property (@(posedge sys_clk) disable iff (reset)
    diagValid_r && $past(pwr_r) == didd_pkg::DIDD_PWR_LOST
    |-> diag_r[`DIDD_DIAG_BIT])
    else $error("Loss not reported in bit 2");

  det_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    !detEn |=> pwr_r == didd_pkg::DIDD_PWR_OK)
    else $error("Detection active while disabled");

  ch_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(state_r[0]) |-> $past(rawIn[0]) == state_r[0])
    else $error("Channel changed without stable input");

  rise_min_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(state_r[0]) |-> $past(rawIn[0], 8) && $past(rawIn[0], 1))
    else $error("Rising edge accepted too early");

  param_load_a: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(live_r) |-> $past(wrHit)
      && $past(avs_address) == `DIDD_OFF_LOAD)
    else $error("Parameters changed without full download");

  fall_min_a: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(state_r[0]) |-> !$past(rawIn[0], 8))
    else $error("Falling edge accepted too early");

  ch_indep_a: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(state_r[2]) |-> $past(rawIn[2]) != $past(state_r[2]))
    else $error("Channel changed without own input");

  bus_wait_a: assert property (@(posedge sys_clk) disable iff (reset)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus request waited more than one cycle");

  load_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(live_r) |-> staged_r == 2'h0)
    else $error("Staged flags kept after load");

  load_both_a: assert property (@(posedge sys_clk) disable iff (reset)
    wrHit && avs_byteenable[0] && avs_address == `DIDD_OFF_LOAD
      && staged_r != 2'h3 |=> $stable(live_r))
    else $error("Partial download applied");

  loss_track_a: assert property (@(posedge sys_clk) disable iff (reset)
    detEn && !fieldPowerOk |=> pwr_r == didd_pkg::DIDD_PWR_LOST)
    else $error("Supply loss not tracked");

  ok_track_a: assert property (@(posedge sys_clk) disable iff (reset)
    detEn && fieldPowerOk |=> pwr_r == didd_pkg::DIDD_PWR_OK)
    else $error("Supply recovery not tracked");

  recov_code_a: assert property (@(posedge sys_clk) disable iff (reset)
    diagValid_r && $past(pwr_r) == didd_pkg::DIDD_PWR_OK
    |-> diag_r == `DIDD_DIAG_NONE)
    else $error("Recovery not reported as zero");

  diag_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(diag_r) |-> diagValid_r || !$past(detEn))
    else $error("Diagnosis byte changed without report");

  irq_diag_a: assert property (@(posedge sys_clk) disable iff (reset)
    diagValid_r |=> irqSt_r[`DIDD_IRQ_DIAG])
    else $error("Report did not set status");

  pend_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    pwrChg |=> pend_r)
    else $error("Supply change not held pending");

  scan_send_a: assert property (@(posedge sys_clk) disable iff (reset)
    scanTick && pend_r && !pwrChg |=> !pend_r && diagValid_r)
    else $error("Pending report not sent at scan");

  diag_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    !detEn && !pend_r |=> diag_r == `DIDD_DIAG_NONE)
    else $error("Diagnosis kept while disabled");

  pend_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    !detEn && !pend_r |=> !pend_r)
    else $error("Report raised while disabled");

  cnt_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    rawIn[3] == state_r[3] |=> gCh[3].cnt_r == '0)
    else $error("Filter count kept after revert");

  irq_input_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(state_r[0]) |-> irqSt_r[`DIDD_IRQ_INPUT])
    else $error("Channel change did not set status");

endmodule : didd_input

/* File: shared/didd_defines.svh */
// Purpose: constants of the debounced digital input block
// Assumes: 20 MHz system clock
// Notes:   offsets are byte addresses of 32-bit words
`ifndef DIDD_DEFINES_SVH
`define DIDD_DEFINES_SVH

`define DIDD_CLK_HZ          20000000
`define DIDD_US_PER_MS       1000
// Filter times in ms, codes 0..7
`define DIDD_T0_MS           1
`define DIDD_T1_MS           3
`define DIDD_T2_MS           5
`define DIDD_T3_MS           10
`define DIDD_T4_MS           15
`define DIDD_T5_MS           20
`define DIDD_T6_MS           25
`define DIDD_T7_MS           30
`define DIDD_MS_CYC(ms)      ((ms) * (`DIDD_CLK_HZ / 1000))

`define DIDD_OFF_FILT        8'h00
`define DIDD_OFF_PWRCTL      8'h04
`define DIDD_OFF_LOAD        8'h08
`define DIDD_OFF_INPUT       8'h0c
`define DIDD_OFF_DIAG        8'h10
`define DIDD_OFF_IRQST       8'h14
`define DIDD_OFF_IRQMSK      8'h18
`define DIDD_OFF_SCAN        8'h1c

`define DIDD_RISE_LSB        0
`define DIDD_FALL_LSB        4
`define DIDD_CODE_W          3
`define DIDD_PDET_BIT        0
`define DIDD_DIAG_BIT        2

`define DIDD_FILT_RST        8'h22
`define DIDD_PWRCTL_RST      8'h01
`define DIDD_DIAG_LOSS       8'h04
`define DIDD_DIAG_NONE       8'h00

`define DIDD_IRQ_DIAG        0
`define DIDD_IRQ_INPUT       1
`define DIDD_IRQ_W           2

`endif

/* File: shared/didd_pkg.sv */
// Purpose: types of the debounced digital input block
// Assumes: nothing
// Notes:   constants live in didd_defines.svh
package didd_pkg;

  typedef enum logic [1:0] {
    DIDD_PWR_OK,
    DIDD_PWR_LOST
  } didd_pwr_e;

  typedef struct packed {
    logic [3:0] fallCode;
    logic [3:0] riseCode;
  } didd_filt_s;

  typedef struct packed {
    logic [7:0]  byte0;
    logic [7:0]  byte1;
  } didd_param_s;

endpackage : didd_pkg

/* File: sim/didd_ctrl_model.sv */
// Purpose: controller side, scan pacing and report log
// Assumes: diagValid is a one-cycle pulse
// Notes:   short scan period keeps the run brief
`timescale 1ns/1ns
module didd_ctrl_model #(
  parameter int SCAN = 200
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       diagValid,
  output logic            scanTick,
  output logic [7:0]      reportCnt,
  output logic [7:0]      lateCnt
);
  int scanCnt_r;
  logic lastTick_r;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scanCnt_r <= 0;
      scanTick  <= 1'b0;
    end else begin
      scanCnt_r <= (scanCnt_r == SCAN - 1) ? 0 : scanCnt_r + 1;
      scanTick  <= (scanCnt_r == SCAN - 1);
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lastTick_r <= 1'b0;
      reportCnt  <= 8'h00;
      lateCnt    <= 8'h00;
    end else begin
      lastTick_r <= scanTick;
      if (diagValid) begin
        reportCnt <= reportCnt + 8'h01;
        if (!lastTick_r) lateCnt <= lateCnt + 8'h01;
      end
    end
  end
endmodule : didd_ctrl_model

/* File: sim/didd_input_tb.sv */
// Purpose: self-checking bench of the debounced input block
// Assumes: filter codes 0 and 1 only, longer ones cost too much time
// Notes:   bus tasks wait for waitrequest low, never a fixed count
`timescale 1ns/1ns
`include "didd_defines.svh"
module didd_input_tb;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] rawIn = 16'h0000;
  logic        fieldPowerOk = 1'b1;
  logic        scanTick;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] inputState;
  logic [7:0]  diagByte;
  logic        diagValid;
  logic        irq;
  logic [7:0]  reportCnt;
  logic [7:0]  lateCnt;
  int          fails = 0;
  int          n_checks = 0;

  always #25 sys_clk = ~sys_clk;

  didd_input dut_u (.sys_clk, .reset, .rawIn, .fieldPowerOk, .scanTick,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .inputState, .diagByte, .diagValid,
    .irq);
  didd_ctrl_model #(.SCAN(200)) ctrl_u (.sys_clk, .reset, .diagValid,
    .scanTick, .reportCnt, .lateCnt);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : wait_cyc

  task automatic download(input logic [7:0] b0, input logic [7:0] b1);
    wr(`DIDD_OFF_PWRCTL, {24'h0, b1});
    wr(`DIDD_OFF_FILT, {24'h0, b0});
    wr(`DIDD_OFF_LOAD, 32'h1);
  endtask : download

  task automatic t_load;
    rd(`DIDD_OFF_DIAG, 32'h0);
    rd(8'h20, 32'h0);
    wr(`DIDD_OFF_FILT, 32'h10);
    wr(`DIDD_OFF_LOAD, 32'h1);
    rawIn <= 16'ha5a5;
    wait_cyc(20100);
    chk(inputState, 16'h0000);
    @(posedge sys_clk);
    rawIn <= 16'h0000;
    download(8'h10, 8'h01);
  endtask : t_load

  // Glitch mid-count must restart the 1 ms rise timer
  task automatic t_filter;
    rawIn <= 16'ha5a5;
    wait_cyc(2000);
    @(posedge sys_clk);
    rawIn <= 16'h0000;
    @(posedge sys_clk);
    rawIn <= 16'ha5a5;
    wait_cyc(19980);
    chk(inputState, 16'h0000);
    wait_cyc(40);
    chk(inputState, 16'ha5a5);
    rd(`DIDD_OFF_INPUT, 32'ha5a5);
    rawIn <= 16'h0000;
    wait_cyc(59980);
    chk(inputState, 16'ha5a5);
    wait_cyc(40);
    chk(inputState, 16'h0000);
  endtask : t_filter

  task automatic t_power;
    wr(`DIDD_OFF_IRQST, 32'h3);
    wr(`DIDD_OFF_IRQMSK, 32'h1);
    fieldPowerOk <= 1'b0;
    wait_cyc(450);
    chk(reportCnt, 8'h01);
    chk(lateCnt, 8'h00);
    chk(diagByte, `DIDD_DIAG_LOSS);
    chk(irq, 1'b1);
    rd(`DIDD_OFF_IRQST, 32'h1);
    wr(`DIDD_OFF_IRQST, 32'h1);
    wait_cyc(1);
    chk(irq, 1'b0);
    @(posedge sys_clk);
    fieldPowerOk <= 1'b1;
    wait_cyc(450);
    chk(reportCnt, 8'h02);
    chk(diagByte, `DIDD_DIAG_NONE);
    wr(`DIDD_OFF_IRQMSK, 32'h0);
    wait_cyc(1);
    chk(irq, 1'b0);
    download(8'h10, 8'h00);
    fieldPowerOk <= 1'b0;
    wait_cyc(450);
    chk(reportCnt, 8'h02);
    chk(lateCnt, 8'h00);
  endtask : t_power

  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    t_load();
    t_filter();
    t_power();
    report_and_stop();
  end

  // Whole run is near 104k cycles; cut off well past that
  initial begin
    #(130000 * 50);
    fails++;
    report_and_stop();
  end
endmodule : didd_input_tb
